// [asb_pkg.sv]
package asb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_THRESHOLD_LOW = 8'h3a;
    localparam logic [7:0] OFS_CONTROL       = 8'h3b;
    localparam logic [7:0] OFS_STATUS_LOW    = 8'h3c;
    localparam logic [7:0] OFS_STATUS_HIGH   = 8'h3d;
    localparam logic [7:0] OFS_CLEAR         = 8'h3e;
    localparam logic [7:0] OFS_READ          = 8'h3f;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_ACTIVE    = 7;
    localparam int BIT_WIDTH_SEL = 6;
    localparam int BIT_FULL_IE   = 5;
    localparam int BIT_TH_HI     = 2;
    localparam int BIT_MODE      = 0;
    localparam int BIT_TRIG_SEEN = 7;
    localparam logic [7:0] RST_THRESHOLD_LOW = 8'h00;
    localparam logic [7:0] RST_CONTROL       = 8'h00;
    localparam logic [7:0] CONTROL_WR_MASK   = 8'hef;

    // ------------------------------------------------------------
    // Capacities
    // ------------------------------------------------------------
    localparam int CAP_SETS_LOW  = 681;
    localparam int CAP_SETS_HIGH = 339;
    localparam int BYTES_LOW     = 3;
    localparam int BYTES_HIGH    = 6;
    localparam int BUF_BYTES     = 2048;

    typedef enum logic [1:0]
    {
        MODE_FIFO    = 2'h0,
        MODE_STREAM  = 2'h1,
        MODE_TRIGGER = 2'h2,
        MODE_LIFO    = 2'h3
    } asb_mode_type;

endpackage

// [asb_ctrl.sv]
`timescale 1ns/100ps

module asb_ctrl
#(
    parameter int DEPTH = asb_pkg::BUF_BYTES
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        operating_enable_i,
    input  wire logic        sample_valid_i,
    input  wire logic [47:0] sample_data_i,
    input  wire logic        trigger_i,
    output logic             watermark_o,
    output logic             interrupt_status_second_o,
    output logic             trigger_seen_o
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Pointers are eleven bits wide, so the ring cannot exceed the full buffer size
    if (DEPTH < asb_pkg::CAP_SETS_LOW * asb_pkg::BYTES_LOW || DEPTH > asb_pkg::BUF_BYTES)
    begin
        $error("DEPTH cannot hold the full buffer");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] threshold_low_r;
    logic [7:0] control_r;
    logic       wr_thl;
    logic       wr_ctl;
    logic       wr_clr;
    logic       rd_buf;

    assign wr_thl = reg_wr_i && reg_addr_i == asb_pkg::OFS_THRESHOLD_LOW;
    assign wr_ctl = reg_wr_i && reg_addr_i == asb_pkg::OFS_CONTROL;
    assign wr_clr = reg_wr_i && reg_addr_i == asb_pkg::OFS_CLEAR;
    assign rd_buf = reg_rd_i && reg_addr_i == asb_pkg::OFS_READ;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Writes while operating_enable is high are still accepted; the host is trusted to stop first
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            threshold_low_r <= asb_pkg::RST_THRESHOLD_LOW;
            control_r       <= asb_pkg::RST_CONTROL;
        end
        else
        begin
            if (wr_thl)
                threshold_low_r <= reg_wdata_i;
            if (wr_ctl)
                control_r <= reg_wdata_i & asb_pkg::CONTROL_WR_MASK;
        end
    end

    // ------------------------------------------------------------
    // Decoded control fields
    // ------------------------------------------------------------
    logic                  active;
    logic                  wide;
    logic                  full_ie;
    asb_pkg::asb_mode_type mode;
    logic [9:0]            sample_threshold;

    assign active           = control_r[asb_pkg::BIT_ACTIVE];
    assign wide             = control_r[asb_pkg::BIT_WIDTH_SEL];
    assign full_ie          = control_r[asb_pkg::BIT_FULL_IE];
    assign mode             = asb_pkg::asb_mode_type'(control_r[asb_pkg::BIT_MODE +: 2]);
    assign sample_threshold = {control_r[asb_pkg::BIT_TH_HI +: 2], threshold_low_r};

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Sets are stored as whole byte groups; a partial pop leaves the set count floored
    logic [7:0]  mem [0:DEPTH-1];
    logic [10:0] head_r;
    logic [10:0] level_r;
    logic [10:0] set_bytes;
    logic [10:0] cap_bytes;
    logic [9:0]  cap_sets;
    logic [9:0]  sets;
    logic        full;
    logic        trig_r;
    logic        trig_stop;
    logic        do_store;
    logic        do_drop;

    // ------------------------------------------------------------
    // Ring arithmetic
    // ------------------------------------------------------------
    // Offsets fold back by hand, so DEPTH need not be a power of two
    function automatic logic [10:0] wrap_add(input logic [10:0] a, input logic [10:0] b);
        logic [11:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= 12'(DEPTH))
            s = s - 12'(DEPTH);
        return s[10:0];
    endfunction

    function automatic logic [10:0] wrap_sub(input logic [10:0] a, input logic [10:0] b);
        logic [11:0] s;
        s = {1'b0, a} + 12'(DEPTH) - {1'b0, b};
        if (s >= 12'(DEPTH))
            s = s - 12'(DEPTH);
        return s[10:0];
    endfunction

    function automatic logic is_trigger(input asb_pkg::asb_mode_type m);
        return m == asb_pkg::MODE_TRIGGER;
    endfunction

    // ------------------------------------------------------------
    // Fill state
    // ------------------------------------------------------------
    assign set_bytes = wide ? 11'(asb_pkg::BYTES_HIGH) : 11'(asb_pkg::BYTES_LOW);
    assign cap_sets  = wide ? 10'(asb_pkg::CAP_SETS_HIGH) : 10'(asb_pkg::CAP_SETS_LOW);
    assign cap_bytes = wide ? 11'(asb_pkg::CAP_SETS_HIGH * asb_pkg::BYTES_HIGH)
                            : 11'(asb_pkg::CAP_SETS_LOW * asb_pkg::BYTES_LOW);
    assign sets      = wide ? 10'(level_r / 11'(asb_pkg::BYTES_HIGH))
                            : 10'(level_r / 11'(asb_pkg::BYTES_LOW));
    // Full means the next whole set would not fit
    assign full      = level_r + set_bytes > cap_bytes;

    // ------------------------------------------------------------
    // Store decision
    // ------------------------------------------------------------
    // Trigger mode: before the trigger hold only threshold sets, afterwards fill and stop
    assign trig_stop = is_trigger(mode) && trig_r && full;
    always_comb
    begin
        do_store = 1'b0;
        do_drop  = 1'b0;
        if (active && sample_valid_i && !rd_buf && !wr_clr)
        begin
            unique case (mode)
                asb_pkg::MODE_FIFO:
                    do_store = !full;
                asb_pkg::MODE_STREAM, asb_pkg::MODE_LIFO:
                begin
                    do_store = 1'b1;
                    do_drop  = full;
                end
                asb_pkg::MODE_TRIGGER:
                begin
                    do_store = !trig_stop;
                    do_drop  = !trig_r && (full || sets >= sample_threshold);
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    logic [10:0] tail;
    assign tail = wrap_add(head_r, level_r);

    // No reset on the array: the level count alone says what is valid
    always_ff @(posedge clk_sys_i)
    begin
        // Only the lanes of the selected width are walked, so no select runs past the input word
        if (do_store && wide)
        begin
            for (int i = 0; i < asb_pkg::BYTES_HIGH; i++)
                mem[wrap_add(tail, 11'(i))] <= sample_data_i[8*i +: 8];
        end
        else if (do_store)
        begin
            for (int i = 0; i < asb_pkg::BYTES_LOW; i++)
                mem[wrap_add(tail, 11'(i))] <= sample_data_i[16*i+8 +: 8];
        end
    end

    // ------------------------------------------------------------
    // Pointers and level
    // ------------------------------------------------------------
    // A read or clear in the same cycle wins; the sample is dropped, not queued
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_r  <= 11'h000;
            level_r <= 11'h000;
        end
        else if (wr_clr)
        begin
            head_r  <= 11'h000;
            level_r <= 11'h000;
        end
        else if (rd_buf && level_r != 11'h000)
        begin
            if (mode != asb_pkg::MODE_LIFO)
                head_r <= wrap_add(head_r, 11'h001);
            level_r <= level_r - 11'h001;
        end
        else if (do_store)
        begin
            if (do_drop)
                head_r <= wrap_add(head_r, set_bytes);
            else
                level_r <= level_r + set_bytes;
        end
    end

    // ------------------------------------------------------------
    // Status and trigger
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            trig_r <= 1'b0;
        // Set wins over clear so a trigger beside a clear write is not lost
        else if (trigger_i && active && is_trigger(mode))
            trig_r <= 1'b1;
        else if (wr_clr || !is_trigger(mode))
            trig_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watermark_o               <= 1'b0;
            interrupt_status_second_o <= 1'b0;
            trigger_seen_o            <= 1'b0;
        end
        else
        begin
            watermark_o <= !is_trigger(mode) && sample_threshold != 10'h000
                           && sets >= sample_threshold;
            interrupt_status_second_o <= full_ie && sets >= cap_sets;
            trigger_seen_o <= trig_r;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [10:0] pop_addr;
    assign pop_addr = mode == asb_pkg::MODE_LIFO ? wrap_sub(tail, 11'h001) : head_r;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                asb_pkg::OFS_THRESHOLD_LOW: reg_rdata_o <= threshold_low_r;
                asb_pkg::OFS_CONTROL:       reg_rdata_o <= control_r;
                asb_pkg::OFS_STATUS_LOW:    reg_rdata_o <= level_r[7:0];
                asb_pkg::OFS_STATUS_HIGH:   reg_rdata_o <= {trig_r, 4'h0, level_r[10:8]};
                asb_pkg::OFS_READ:          reg_rdata_o <= level_r != 11'h000 ? mem[pop_addr] : 8'h00;
                default:                    reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule

// [asb_monitor.sv]
`timescale 1ns/100ps
module asb_monitor
(
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       sample_valid_i,
    input wire logic       watermark_o,
    input wire logic       interrupt_status_second_o,
    input wire logic       trigger_seen_o
);
    logic [7:0] ctl_r;
    logic [7:0] th_r;
    logic       trig_mode;
    logic       smp_taken;

    default clocking mon_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // Shadow copies of the control registers, so no internal probes are needed
    assign trig_mode = ctl_r[1:0] == 2'h2;
    assign smp_taken = sample_valid_i && ctl_r[7];

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctl_r <= 8'h00;
            th_r  <= 8'h00;
        end
        else if (reg_wr_i && reg_addr_i == 8'h3b)
            ctl_r <= reg_wdata_i & 8'hef;
        else if (reg_wr_i && reg_addr_i == 8'h3a)
            th_r <= reg_wdata_i;
    end

    a_wm_has_cause: assert property ($rose(watermark_o) |-> $past(smp_taken, 2) || $past(reg_wr_i, 2))
        else $error("watermark rose without stored sample or write");
    a_wm_not_trig: assert property (watermark_o |-> !(trig_mode && $past(trig_mode) && $past(trig_mode, 2)))
        else $error("watermark in trigger mode");
    a_ctl_readback: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 8'h3b |=> reg_rdata_o == ctl_r)
        else $error("control readback wrong");
    a_th_readback: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 8'h3a |=> reg_rdata_o == th_r)
        else $error("threshold readback wrong");
    a_status_hi_zero: assert property (reg_rd_i && reg_addr_i == 8'h3d |=> reg_rdata_o[6:3] == 4'h0)
        else $error("status high unused bits set");
    a_full_needs_ie: assert property (interrupt_status_second_o |-> ctl_r[5] || $past(ctl_r[5]) || $past(ctl_r[5], 2))
        else $error("full flag with enable clear");
    a_clear_status: assert property (reg_wr_i && reg_addr_i == 8'h3e |=> ##1 !watermark_o && !interrupt_status_second_o)
        else $error("status not cleared");
    a_trig_seen_mode: assert property (trigger_seen_o |-> trig_mode || $past(trig_mode) || $past(trig_mode, 2))
        else $error("trigger seen outside trigger mode");
endmodule

bind asb_ctrl asb_monitor u_mon
(
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .sample_valid_i(sample_valid_i), .watermark_o(watermark_o),
    .interrupt_status_second_o(interrupt_status_second_o), .trigger_seen_o(trigger_seen_o)
);

// [asb_host_model.sv]
`timescale 1ns/100ps
module asb_host_model
(
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            operating_enable_o
);
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        operating_enable_o = 1'b1;
    end

    // Operation is halted around every write; cheaper than tracking which offsets need it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        operating_enable_o <= 1'b0;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
        operating_enable_o <= 1'b1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, operating_enable_i, sample_valid_i, trigger_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
    logic [47:0] sample_data_i;
    logic        watermark_o, interrupt_status_second_o, trigger_seen_o;
    int          mismatches, num_checks;

    asb_ctrl uut
    (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .operating_enable_i(operating_enable_i), .sample_valid_i(sample_valid_i),
        .sample_data_i(sample_data_i), .trigger_i(trigger_i), .watermark_o(watermark_o),
        .interrupt_status_second_o(interrupt_status_second_o), .trigger_seen_o(trigger_seen_o)
    );
    asb_host_model host
    (
        .clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .operating_enable_o(operating_enable_i)
    );

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        chk(rv, exp);
    endtask

    // Sample k carries k in X low and Z high bytes, so order shows in both widths
    task automatic fill(input int n);
        for (int k = 1; k <= n; k++)
        begin
            @(posedge clk_sys_i);
            sample_valid_i <= 1'b1;
            sample_data_i <= {k[7:0], 8'h55, 8'h33, 8'h22, 8'h11, k[7:0]};
            @(posedge clk_sys_i);
            sample_valid_i <= 1'b0;
            sample_data_i <= ~sample_data_i;
        end
    endtask

    task automatic cfg(input logic [7:0] th, input logic [7:0] ctl);
        host.wr(8'h3e, 8'h00);
        host.wr(8'h3a, th);
        host.wr(8'h3b, ctl);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        close_out();
    end

    initial
    begin
        rst_n_i = 1'b0;
        sample_valid_i = 1'b0;
        sample_data_i = 48'h0000_0000_0000;
        trigger_i = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rc(8'h3a, 8'h00);
        rc(8'h3b, 8'h00);
        rc(8'h20, 8'h00);
        cfg(8'h02, 8'h5d);
        rc(8'h3b, 8'h4d);
        fill(1);
        rc(8'h3c, 8'h00);
        cfg(8'h02, 8'hc0);
        fill(3);
        rc(8'h3c, 8'h12);
        chk({7'h0, watermark_o}, 8'h01);
        rc(8'h3f, 8'h01);
        rc(8'h3f, 8'h11);
        rc(8'h3c, 8'h10);
        cfg(8'h01, 8'h83);
        fill(2);
        rc(8'h3f, 8'h02);
        rc(8'h3f, 8'h33);
        rc(8'h3c, 8'h04);
        host.wr(8'h3e, 8'ha5);
        rc(8'h3c, 8'h00);
        chk({7'h0, watermark_o}, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            cfg(8'h00, 8'he0 | m[7:0]);
            fill(340);
            chk({7'h0, interrupt_status_second_o}, 8'h01);
            host.wr(8'h3b, 8'hc0 | m[7:0]);
            rc(8'h3c, 8'hf2);
            rc(8'h3d, 8'h07);
            chk({7'h0, interrupt_status_second_o}, 8'h00);
            rc(8'h3f, 8'h01 + m[7:0]);
        end
        cfg(8'h02, 8'h82);
        fill(5);
        chk({7'h0, trigger_seen_o}, 8'h00);
        rc(8'h3c, 8'h06);
        @(posedge clk_sys_i);
        trigger_i <= 1'b1;
        @(posedge clk_sys_i);
        trigger_i <= 1'b0;
        fill(1);
        rc(8'h3d, 8'h80);
        chk({7'h0, trigger_seen_o}, 8'h01);
        rc(8'h3c, 8'h09);
        close_out();
    end
endmodule
